// ==== rtl/adcht_defines.svh ====
`ifndef ADCHT_DEFINES_SVH
`define ADCHT_DEFINES_SVH
// Clock period of core_clk in ns
`define ADCHT_CLK_NS        40
// Busy delay, conversion, acquisition, reset and data-out windows in ns
`define ADCHT_BUSY_DLY_NS   32
`define ADCHT_CONV_TYP_NS   700
`define ADCHT_CONV_MAX_NS   800
`define ADCHT_ACQ_MIN_NS    200
`define ADCHT_ACQB_MIN_NS   550
`define ADCHT_ACQB_TYP_NS   600
`define ADCHT_RSTP_MIN_NS   100
`define ADCHT_RSTP_MAX_NS   500
`define ADCHT_RSTF_MIN_NS   1200
`define ADCHT_DOUT_MAX_NS   30
// Derived counts: least times round up, longest round down
`define ADCHT_CONV_CYC  (`ADCHT_CONV_TYP_NS / `ADCHT_CLK_NS)
`define ADCHT_ACQ_CYC   ((`ADCHT_ACQ_MIN_NS + `ADCHT_CLK_NS - 1) / `ADCHT_CLK_NS)
`define ADCHT_ACQB_CYC  (`ADCHT_ACQB_TYP_NS / `ADCHT_CLK_NS)
`define ADCHT_RSTP_CYC  ((`ADCHT_RSTP_MIN_NS + `ADCHT_CLK_NS - 1) / `ADCHT_CLK_NS)
`define ADCHT_RSTPX_CYC (`ADCHT_RSTP_MAX_NS / `ADCHT_CLK_NS)
`define ADCHT_RSTF_CYC  ((`ADCHT_RSTF_MIN_NS + `ADCHT_CLK_NS - 1) / `ADCHT_CLK_NS)
// Serial frame length: two 16-bit results
`define ADCHT_FRAME_BITS 32
`endif

// ==== rtl/adcht_pkg.sv ====
`default_nettype none
package adcht_pkg;
    typedef enum logic [3:0] {
        ADCHT_IDLE = 4'b0001,
        ADCHT_ACQ  = 4'b0010,
        ADCHT_CONV = 4'b0100,
        ADCHT_DONE = 4'b1000
    } adcht_state_t;
    typedef enum logic [1:0] {
        ADCHT_RST_NONE    = 2'h0,
        ADCHT_RST_PARTIAL = 2'h1,
        ADCHT_RST_FULL    = 2'h2
    } adcht_rst_kind_t;
endpackage : adcht_pkg
`default_nettype wire

// ==== rtl/adcht_xfer_if.sv ====
`default_nettype none
// Word handover between core and serial-clock domains
interface adcht_xfer_if;
    logic [31:0] result;    // Core-held pair of results
    logic        res_tgl;   // Toggles when result is new
    logic [15:0] cfg_word;  // Last serial word received
    logic        cfg_tgl;   // Toggles when cfg_word is new
    modport core (output result, output res_tgl,
                  input cfg_word, input cfg_tgl);
    modport link (input result, input res_tgl,
                  output cfg_word, output cfg_tgl);
endinterface : adcht_xfer_if
`default_nettype wire

// ==== rtl/adcht_serial_link.sv ====
`default_nettype none
`include "adcht_defines.svh"
module adcht_serial_link
    import adcht_pkg::*;
(
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output var  logic [1:0] serial_data_out,
    adcht_xfer_if.link      xf
);
    logic [4:0]  tx_cnt_reg;
    logic [15:0] rx_reg;
    logic [4:0]  rx_cnt_reg;
    logic        cfg_tgl_reg = 1'b0;
    logic [15:0] cfg_word_reg;

    // Bit index steps on each rising edge; cs_n high parks it at the MSB.
    // The result word changes whenever a conversion completes, whether or not a frame is open.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_cnt_reg <= 5'h0;
        end else begin
            tx_cnt_reg <= tx_cnt_reg + 5'h1;
        end
    end

    // Launch after rising edge: A result on lane 0, B on lane 1
    always_comb begin
        serial_data_out = {xf.result[15 - tx_cnt_reg[3:0]],
                           xf.result[31 - tx_cnt_reg[3:0]]};
    end

    // Capture on falling edge
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rx_cnt_reg <= 5'h0;
        end else begin
            rx_reg     <= {rx_reg[14:0], sdi};
            rx_cnt_reg <= rx_cnt_reg + 5'h1;
        end
    end

    // Publish a completed 16-bit word by toggle
    always_ff @(negedge sclk) begin
        if (!cs_n && rx_cnt_reg == 5'hf) begin
            cfg_word_reg <= {rx_reg[14:0], sdi};
            cfg_tgl_reg  <= ~cfg_tgl_reg;
        end
    end

    assign xf.cfg_word = cfg_word_reg;
    assign xf.cfg_tgl  = cfg_tgl_reg;
endmodule : adcht_serial_link
`default_nettype wire

// ==== rtl/adcht_reset_sizer.sv ====
`default_nettype none
`include "adcht_defines.svh"
module adcht_reset_sizer
    import adcht_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst_sync_n,
    input  wire logic            reset_in_s,
    output var  logic [1:0]      rst_kind,
    output var  logic            rst_pulse
);
    logic [6:0] low_cnt_reg;
    logic       prev_reg;

    // Measure low width of the synchronised reset pin
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_cnt_reg <= 7'h0;
            prev_reg    <= 1'b1;
        end else begin
            prev_reg <= reset_in_s;
            if (!reset_in_s && low_cnt_reg != 7'h7f) begin
                low_cnt_reg <= low_cnt_reg + 7'h1;
            end else if (reset_in_s) begin
                low_cnt_reg <= 7'h0;
            end
        end
    end

    // Classify on release; widths between windows are ignored
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rst_kind  <= ADCHT_RST_NONE;
            rst_pulse <= 1'b0;
        end else begin
            rst_pulse <= 1'b0;
            if (reset_in_s && !prev_reg) begin
                if (low_cnt_reg >= 7'(`ADCHT_RSTF_CYC)) begin
                    rst_kind  <= ADCHT_RST_FULL;
                    rst_pulse <= 1'b1;
                end else if (low_cnt_reg >= 7'(`ADCHT_RSTP_CYC) &&
                             low_cnt_reg <= 7'(`ADCHT_RSTPX_CYC)) begin
                    rst_kind  <= ADCHT_RST_PARTIAL;
                    rst_pulse <= 1'b1;
                end
            end
        end
    end
endmodule : adcht_reset_sizer
`default_nettype wire

// ==== rtl/adcht_conv_ctrl.sv ====
`default_nettype none
`include "adcht_defines.svh"
// Functional notes
// - Busy rises within 32 ns of start; the code raises it on the third core_clk rising edge after start
// - Conversion ends within 800 ns
// - Acquisition of at least 200 ns precedes conversion
// - Burst acquisition at least 550 ns
// - Reset low 100-500 ns is partial
// - Reset low 1.2 us or more is full
// - Parallel data valid 30 ns after read; the code loads the bus on the third core_clk rising edge after rd_n falls
// - Serial data launched after rising edge
// - Serial input captured on falling edge
// - Hardware mode uses pins, software uses registers
module adcht_conv_ctrl
    import adcht_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              conversion_start,
    input  wire logic              reset_in_n,
    input  wire logic              burst_mode,
    input  wire logic [2:0]        channel_select_pins,
    input  wire logic [1:0]        range_select_pins,
    input  wire logic [DATA_W-1:0] sample_a,
    input  wire logic [DATA_W-1:0] sample_b,
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [15:0]       db_in,
    output var  logic [15:0]       parallel_data_bus,
    output var  logic              db_oe,
    output var  logic              busy,
    output var  logic [2:0]        active_channel,
    output var  logic [1:0]        active_range,
    output var  logic              sw_mode,
    output var  logic [15:0]       config_word,
    output var  logic [1:0]        reset_kind,
    input  wire logic              sclk,
    input  wire logic              sdi,
    output var  logic [1:0]        serial_data_out
);
    logic [1:0]  rst_sync_reg;
    logic        rst_sync_n;
    logic [1:0]  cv_sync_reg;
    logic [1:0]  rs_sync_reg;
    logic [1:0]  cs_sync_reg;
    logic [1:0]  rd_sync_reg;
    logic [1:0]  wr_sync_reg;
    logic [1:0]  ct_sync_reg;
    logic        ct_prev_reg;
    logic        cv_prev_reg;
    logic        rd_prev_reg;
    logic        wr_prev_reg;
    logic        start_rise;
    adcht_state_t state_reg;
    logic [4:0]  cnt_reg;
    logic [31:0] result_reg;
    logic        res_tgl_reg;
    logic [1:0]  rd_idx_reg;
    logic [1:0]  rst_kind;
    logic        rst_pulse;
    adcht_xfer_if xf ();

    // Release reset through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_reg[1];

    // Two-flop synchronisers for the start, reset, select and strobe pins and the serial word toggle
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cv_sync_reg <= 2'h0;
            rs_sync_reg <= 2'h3;
            cs_sync_reg <= 2'h3;
            rd_sync_reg <= 2'h3;
            wr_sync_reg <= 2'h3;
            ct_sync_reg <= 2'h0;
        end else begin
            cv_sync_reg <= {cv_sync_reg[0], conversion_start};
            rs_sync_reg <= {rs_sync_reg[0], reset_in_n};
            cs_sync_reg <= {cs_sync_reg[0], cs_n};
            rd_sync_reg <= {rd_sync_reg[0], rd_n};
            wr_sync_reg <= {wr_sync_reg[0], wr_n};
            ct_sync_reg <= {ct_sync_reg[0], xf.cfg_tgl};
        end
    end

    // Edge history on synchronised copies only
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cv_prev_reg <= 1'b0;
            rd_prev_reg <= 1'b1;
            wr_prev_reg <= 1'b1;
            ct_prev_reg <= 1'b0;
        end else begin
            cv_prev_reg <= cv_sync_reg[1];
            rd_prev_reg <= rd_sync_reg[1];
            wr_prev_reg <= wr_sync_reg[1];
            ct_prev_reg <= ct_sync_reg[1];
        end
    end
    assign start_rise = cv_sync_reg[1] && !cv_prev_reg;

    adcht_reset_sizer u_rsz (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .reset_in_s (rs_sync_reg[1]),
        .rst_kind   (rst_kind),
        .rst_pulse  (rst_pulse)
    );
    assign reset_kind = rst_kind;

    // Conversion sequencer; starts during a conversion are ignored
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= ADCHT_IDLE;
            cnt_reg   <= 5'h0;
        end else if (!rs_sync_reg[1] || rst_pulse) begin
            state_reg <= ADCHT_IDLE;
            cnt_reg   <= 5'h0;
        end else begin
            unique case (state_reg)
                ADCHT_IDLE: begin
                    if (start_rise) begin
                        state_reg <= ADCHT_ACQ;
                        cnt_reg   <= burst_mode ? 5'(`ADCHT_ACQB_CYC)
                                                : 5'(`ADCHT_ACQ_CYC);
                    end
                end
                ADCHT_ACQ: begin
                    if (cnt_reg <= 5'h1) begin
                        state_reg <= ADCHT_CONV;
                        cnt_reg   <= 5'(`ADCHT_CONV_CYC);
                    end else begin
                        cnt_reg <= cnt_reg - 5'h1;
                    end
                end
                ADCHT_CONV: begin
                    if (cnt_reg <= 5'h1) begin
                        state_reg <= ADCHT_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 5'h1;
                    end
                end
                ADCHT_DONE: begin
                    state_reg <= ADCHT_IDLE;
                end
            endcase
        end
    end

    // Busy covers acquisition and conversion; it is raised on the cycle
    // after the synchronised edge, the closest this clock can reach.
    assign busy = (state_reg == ADCHT_ACQ) ||
                  (state_reg == ADCHT_CONV);

    // Latch the result pair as conversion completes
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result_reg  <= 32'h0;
            res_tgl_reg <= 1'b0;
        end else if (state_reg == ADCHT_CONV && cnt_reg <= 5'h1) begin
            result_reg  <= {sample_a, sample_b};
            res_tgl_reg <= ~res_tgl_reg;
        end
    end
    assign xf.result  = result_reg;
    assign xf.res_tgl = res_tgl_reg;

    // Mode and channel: pins in hardware mode, written word otherwise
    assign sw_mode = (range_select_pins == 2'h0);
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            config_word <= 16'h0;
        end else if (!cs_sync_reg[1] && wr_sync_reg[1] && !wr_prev_reg) begin
            config_word <= db_in;
        end else if (ct_sync_reg[1] != ct_prev_reg) begin
            config_word <= xf.cfg_word;
        end
    end

    // Capture pins or written word at start so they hold through the conversion
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            active_channel <= 3'h0;
            active_range   <= 2'h0;
        end else if (start_rise && state_reg == ADCHT_IDLE) begin
            active_channel <= sw_mode ? config_word[2:0]
                                      : channel_select_pins;
            active_range   <= sw_mode ? config_word[4:3]
                                      : range_select_pins;
        end
    end

    // Parallel read: A then B on successive read strobes
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_idx_reg        <= 2'h0;
            parallel_data_bus <= 16'h0;
        end else if (cs_sync_reg[1]) begin
            rd_idx_reg <= 2'h0;
        end else if (!rd_sync_reg[1] && rd_prev_reg) begin
            parallel_data_bus <= rd_idx_reg[0] ? result_reg[15:0]
                                               : result_reg[31:16];
            rd_idx_reg        <= rd_idx_reg + 2'h1;
        end
    end
    // Drive the bus only while selected and reading
    assign db_oe = !cs_sync_reg[1] && !rd_sync_reg[1];

    adcht_serial_link u_ser (
        .sclk            (sclk),
        .cs_n            (cs_n),
        .sdi             (sdi),
        .serial_data_out (serial_data_out),
        .xf              (xf.link)
    );
endmodule : adcht_conv_ctrl
`default_nettype wire

// ==== bench/adcht_conv_ctrl_asserts.sv ====
`default_nettype none
`include "adcht_defines.svh"
// Port-level timing checks on the conversion controller
module adcht_conv_ctrl_asserts (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       conversion_start,
    input wire logic       reset_in_n,
    input wire logic       burst_mode,
    input wire logic [2:0] channel_select_pins,
    input wire logic [1:0] range_select_pins,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       sclk,
    input wire logic       busy,
    input wire logic       db_oe,
    input wire logic [2:0] active_channel,
    input wire logic [1:0] active_range,
    input wire logic [1:0] reset_kind,
    input wire logic [1:0] serial_data_out
);
    // Busy spans acquisition plus conversion; 800 ns caps conversion
    localparam int NLO = `ADCHT_ACQ_CYC + `ADCHT_CONV_CYC - 1;
    localparam int NHI = `ADCHT_ACQ_CYC + 20;
    localparam int BLO = `ADCHT_ACQB_CYC + `ADCHT_CONV_CYC - 1;
    localparam int BHI = `ADCHT_ACQB_CYC + 20;
    logic [5:0] busy_cnt;
    logic [5:0] low_cnt;
    logic       hit;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Length of the current busy spell
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) busy_cnt <= 6'h00;
        else busy_cnt <= busy ? busy_cnt + 6'h01 : 6'h00;
    end
    // Reset pin low width, saturating so long pulses stay full
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 6'h00;
        else low_cnt <= reset_in_n ? 6'h00 : low_cnt + {5'h00, ~&low_cnt};
    end
    // An abort cuts busy short, so its spell is not measured
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) hit <= 1'b0;
        else hit <= busy & (hit | ~reset_in_n);
    end
    property p_busy_rise;
        $rose(conversion_start) && !busy && reset_in_n |-> ##[1:4] busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy late after start");
    property p_busy_norm;
        $fell(busy) && !hit && !burst_mode |-> busy_cnt >= NLO && busy_cnt <= NHI;
    endproperty
    a_busy_norm: assert property (p_busy_norm)
        else $error("busy length wrong");
    property p_busy_burst;
        $fell(busy) && !hit && burst_mode |-> busy_cnt >= BLO && busy_cnt <= BHI;
    endproperty
    a_busy_burst: assert property (p_busy_burst)
        else $error("burst busy length wrong");
    property p_db_on;
        (!cs_n && !rd_n) [*4] |-> db_oe;
    endproperty
    a_db_on: assert property (p_db_on)
        else $error("data bus not driven in read");
    property p_sdo_hold;
        !sclk && !$past(sclk) && !cs_n |-> $stable(serial_data_out);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold)
        else $error("serial data moved in low phase");
    property p_rst_part;
        $rose(reset_in_n) && low_cnt >= 6'd4 && low_cnt <= 6'd11
            |-> ##[1:6] reset_kind == 2'h1;
    endproperty
    a_rst_part: assert property (p_rst_part)
        else $error("partial reset not seen");
    property p_rst_full;
        $rose(reset_in_n) && low_cnt >= 6'd31 |-> ##[1:6] reset_kind == 2'h2;
    endproperty
    a_rst_full: assert property (p_rst_full)
        else $error("full reset not seen");
    property p_hw_cfg;
        $rose(busy) && range_select_pins != 2'h0 |-> ##1
            active_channel == channel_select_pins &&
            active_range == range_select_pins;
    endproperty
    a_hw_cfg: assert property (p_hw_cfg)
        else $error("pin configuration not taken");
endmodule : adcht_conv_ctrl_asserts
`default_nettype wire

// ==== bench/adcht_serial_host.sv ====
`default_nettype none
// Serial host; its clock idles high and stands still between frames
module adcht_serial_host (
    output logic            sclk,
    output logic            cs_n,
    output logic            sdi,
    input  wire logic [1:0] serial_data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;  // 125 ns link period
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // One 16-clock frame; sdi moves mid low phase, clear of both edges
    task automatic frame(input logic [15:0] wd, output logic [15:0] a,
                         output logic [15:0] b);
        sdi = wd[15];
        cs_n = 1'b0;
        #HALF;
        for (int i = 15; i >= 0; i--) begin
            a[i] = serial_data_out[0];
            b[i] = serial_data_out[1];
            sclk = 1'b0;
            #(HALF / 2);
            if (i > 0) sdi = wd[i - 1];
            #(HALF / 2);
            sclk = 1'b1;
            #HALF;
        end
        cs_n = 1'b1;
        sdi = ~sdi;  // Released line does not keep its last value
    endtask : frame
endmodule : adcht_serial_host
`default_nettype wire

// ==== bench/adc_conversion_host_timing_test.sv ====
`default_nettype none
`include "adcht_defines.svh"
bind adcht_conv_ctrl adcht_conv_ctrl_asserts i_adcht_conv_ctrl_asserts (
    .core_clk, .rst_n, .conversion_start, .reset_in_n, .burst_mode,
    .channel_select_pins, .range_select_pins, .cs_n, .rd_n, .sclk, .busy,
    .db_oe, .active_channel, .active_range, .reset_kind, .serial_data_out);
module adc_conversion_host_timing_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        burst;
        logic [2:0]  chan;
        logic [1:0]  rng;
        logic [15:0] sa;
        logic [15:0] sb;
        logic [2:0]  ech;
        logic [1:0]  erg;
    } adcht_row_t;
    // Range pins 00 hands channel and range to the written word 0x001d
    adcht_row_t rows [4] = '{
        '{1'b0, 3'h1, 2'h1, 16'h1234, 16'hfedc, 3'h1, 2'h1},
        '{1'b1, 3'h6, 2'h2, 16'h8001, 16'h7ffe, 3'h6, 2'h2},
        '{1'b0, 3'h7, 2'h3, 16'hffff, 16'h0000, 3'h7, 2'h3},
        '{1'b1, 3'h2, 2'h0, 16'ha5a5, 16'h5a5a, 3'h5, 2'h3}};
    localparam int LIMIT = 5000;
    logic        core_clk, rst_n, conversion_start, reset_in_n, burst_mode;
    logic        rd_n, wr_n, p_cs_n, sdi, sclk, s_cs_n, busy, db_oe, sw_mode;
    logic [2:0]  channel_select_pins, active_channel;
    logic [1:0]  range_select_pins, active_range, reset_kind, serial_data_out;
    logic [15:0] sample_a, sample_b, db_in, parallel_data_bus, config_word;
    logic [15:0] a, b;
    wire logic   cs_n;
    int          failures = 0, num_checks = 0, cycles = 0, len;
    assign cs_n = p_cs_n & s_cs_n;
    adcht_conv_ctrl i_adcht_conv_ctrl (.core_clk, .rst_n, .conversion_start,
        .reset_in_n, .burst_mode, .channel_select_pins, .range_select_pins,
        .sample_a, .sample_b, .cs_n, .rd_n, .wr_n, .db_in, .parallel_data_bus,
        .db_oe, .busy, .active_channel, .active_range, .sw_mode, .config_word,
        .reset_kind, .sclk, .sdi, .serial_data_out);
    adcht_serial_host i_adcht_serial_host (.sclk, .cs_n(s_cs_n), .sdi,
        .serial_data_out);
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Hang guard; a full run needs about 600 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("ERROR %0t ns: timeout", $time);
            end_sim();
        end
    end
    // Start pulse of at most 80 ns, then time busy in cycles
    task automatic conv(input logic burst);
        int w;
        int acq;
        w = 0;
        len = 0;
        acq = burst ? `ADCHT_ACQB_CYC : `ADCHT_ACQ_CYC;
        @(negedge core_clk) conversion_start = 1'b1;
        while (busy !== 1'b1 && w < 8) begin
            @(negedge core_clk);
            w++;
            if (w == 2) conversion_start = 1'b0;
        end
        conversion_start = 1'b0;
        chk(w, 3);
        while (busy === 1'b1 && len < 60) begin
            @(negedge core_clk);
            len++;
        end
        chk(len >= acq + 16 && len <= acq + 20, 1);
        repeat (2) @(negedge core_clk);
    endtask : conv
    // Read A then B in one select
    task automatic pread;
        @(negedge core_clk) p_cs_n = 1'b0;
        @(negedge core_clk) rd_n = 1'b0;
        repeat (4) @(negedge core_clk);
        a = parallel_data_bus;
        rd_n = 1'b1;
        repeat (2) @(negedge core_clk);
        rd_n = 1'b0;
        repeat (4) @(negedge core_clk);
        b = parallel_data_bus;
        rd_n = 1'b1;
        @(negedge core_clk) p_cs_n = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask : pread
    initial begin
        {rst_n, conversion_start, burst_mode, channel_select_pins} = '0;
        {range_select_pins, sample_a, sample_b, db_in} = '0;
        {reset_in_n, p_cs_n, rd_n, wr_n} = 4'hf;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({busy, reset_kind}, 3'h0);
        // Configuration write while range pins select software mode
        p_cs_n = 1'b0;
        db_in = 16'h001d;
        @(negedge core_clk) wr_n = 1'b0;
        repeat (3) @(negedge core_clk);
        wr_n = 1'b1;
        // Data and select held until the synchronised strobe edge is taken
        repeat (3) @(negedge core_clk);
        p_cs_n = 1'b1;
        @(negedge core_clk) db_in = 16'hffe2;
        repeat (4) @(negedge core_clk);
        chk({sw_mode, config_word}, 17'h1001d);
        foreach (rows[i]) begin
            burst_mode = rows[i].burst;
            channel_select_pins = rows[i].chan;
            range_select_pins = rows[i].rng;
            sample_a = rows[i].sa;
            sample_b = rows[i].sb;
            repeat (6) @(negedge core_clk);
            conv(rows[i].burst);
            chk({active_channel, active_range}, {rows[i].ech, rows[i].erg});
            pread();
            chk({a, b}, {rows[i].sa, rows[i].sb});
            i_adcht_serial_host.frame(16'h001d, a, b);
            chk({a, b}, {rows[i].sa, rows[i].sb});
            repeat (4) @(negedge core_clk);
        end
        // Second start while busy is ignored
        burst_mode = 1'b0;
        fork
            conv(1'b0);
            begin
                repeat (8) @(negedge core_clk);
                conversion_start = 1'b1;
                repeat (2) @(negedge core_clk);
                conversion_start = 1'b0;
            end
        join
        repeat (6) @(negedge core_clk);
        chk(busy, 0);
        // Partial reset pulse of 200 ns aborts a conversion
        @(negedge core_clk) conversion_start = 1'b1;
        repeat (8) @(negedge core_clk);
        conversion_start = 1'b0;
        reset_in_n = 1'b0;
        repeat (5) @(negedge core_clk);
        reset_in_n = 1'b1;
        repeat (8) @(negedge core_clk);
        chk({busy, reset_kind}, 3'h1);
        conv(1'b0);
        // Full reset pulse of 1.4 us; no start may follow for 15 ms
        reset_in_n = 1'b0;
        repeat (35) @(negedge core_clk);
        reset_in_n = 1'b1;
        repeat (8) @(negedge core_clk);
        chk(reset_kind, 2);
        end_sim();
    end
endmodule : adc_conversion_host_timing_test
`default_nettype wire
